// *** pbsel_pkg.sv ***
// package for the port pin function select block
package pbsel_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [3:0] PBSEL_OFS_DATA = 4'h0;
  localparam logic [3:0] PBSEL_OFS_DIR  = 4'h4;
  localparam logic [3:0] PBSEL_OFS_PAT  = 4'h8;
  localparam logic [3:0] PBSEL_OFS_PIN  = 4'hC;

  // reset values
  localparam logic [7:0] PBSEL_DATA_RST = 8'h00;
  localparam logic [7:0] PBSEL_DIR_RST  = 8'h00;
  localparam logic [7:0] PBSEL_PAT_RST  = 8'h00;

  // pin positions
  localparam int PBSEL_PIN_RX   = 7;
  localparam int PBSEL_PIN_TX   = 6;
  localparam int PBSEL_PIN_SCK  = 5;
  localparam int PBSEL_PIN_UPPER_COLUMN_STROBE = 4;
  localparam int PBSEL_PIN_3    = 3;
  localparam int PBSEL_PIN_2    = 2;
  localparam int PBSEL_PIN_1    = 1;
  localparam int PBSEL_PIN_0    = 0;

  // control bits owned by neighbouring units
  typedef struct packed {
    logic       rx_enable;
    logic       tx_enable;
    logic       smart_card_flag;
    logic       clock_enable_bit0;
    logic       clock_enable_bit1;
    logic       sync_mode;
    logic [2:0] dram_area_select;
    logic       strobe_select;
    logic [3:0] timer_output_select_nz; // per 8-bit timer 3..0
    logic [1:0] counter_clear_sel_hi;   // timers 3 and 1
    logic [1:0] counter_clear_sel_lo;
    logic       select4_enable;
    logic       select5_enable;
    logic       select6_enable;
    logic       select7_enable;
    logic       dma_ext_request;
  } pbsel_ctrl_t;

  // output-side signals from the peripherals
  typedef struct packed {
    logic [7:0] pattern_out;
    logic       serial2_transmit;
    logic       serial2_tx_drive;
    logic       serial2_clock_out;
    logic       upper_column_strobe;
    logic       lower_column_strobe;
    logic       cas_enable;
    logic [3:0] timer_out;
    logic [7:4] select_n;
  } pbsel_periph_t;

  // input-side signals to the peripherals
  typedef struct packed {
    logic serial2_receive;
    logic serial2_clock_in;
    logic timer3_pin;
    logic timer1_pin;
    logic dma_request_1;
    logic dma_request_0;
  } pbsel_feed_t;

endpackage

// *** pbsel_top.sv ***
// port pin function select with port data and direction registers
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - data register clears on reset, hardware standby
// - data register kept in software standby
// - free pin: input, data or pattern
// - pin 7 receive when rx or card
// - pin 6 transmit, card mode may float
// - pin 5 serial clock in or out
// - pins 4,5 column strobes when dram enabled
// - pin 3 priority dram, timer, select
// - pin 2 priority dram, timer, select
// - pin 1 timer, then select six
// - pin 0 timer, then select seven
// - pins 3,1 feed timer clear inputs
// - pins 3,1 feed dma requests when dma_ext_request set
// - read gives data or pin level
// - direction clears on reset, hardware standby
module pbsel_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   hw_standby_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire pbsel_pkg::pbsel_ctrl_t   ctrl_i,
  input  wire pbsel_pkg::pbsel_periph_t periph_i,
  output pbsel_pkg::pbsel_feed_t        feed_o,
  input  wire logic [7:0]             pin_i,
  output logic      [7:0]             pin_o,
  output logic      [7:0]             pin_oe_o
);
  import pbsel_pkg::*;

  logic [7:0] data_r, data_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] pat_r, pat_nxt;
  logic [7:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic       ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic       area4, area5, cas_on;

  // dram area setting covers a row strobe area
  function automatic logic covers(input logic [2:0] a, input logic hi);
    covers = hi ? (a == 3'h4 || a == 3'h5)
                : (a == 3'h2 || a == 3'h3 || a == 3'h4 || a == 3'h5);
  endfunction

  // pin synchroniser, level taken when stages two and three agree
  always_ff @(posedge clk_i)
  begin
    s1_r <= pin_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  always_comb
  begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 8; i++)
    begin
      if (s2_r[i] == s3_r[i])
        lvl_nxt[i] = s3_r[i];
    end
  end

  // wishbone slave, one wait-free answer a cycle after the strobe
  always_comb
  begin
    data_nxt = data_r;
    dir_nxt  = dir_r;
    pat_nxt  = pat_r;
    rdat_nxt = 32'h0000_0000;
    ack_nxt  = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack_r)
    begin
      ack_nxt = 1'b1;
      if (wb_we_i && wb_sel_i[0])
      begin
        unique case (wb_adr_i)
          PBSEL_OFS_DATA: data_nxt = wb_dat_i[7:0];
          PBSEL_OFS_DIR:  dir_nxt  = wb_dat_i[7:0];
          PBSEL_OFS_PAT:  pat_nxt  = wb_dat_i[7:0];
          default:        data_nxt = data_r;
        endcase
      end
      else if (!wb_we_i)
      begin
        unique case (wb_adr_i)
          PBSEL_OFS_DATA: rdat_nxt = {24'h00_0000,
                                      (data_r & dir_r) | (lvl_r & ~dir_r)};
          PBSEL_OFS_DIR:  rdat_nxt = 32'h0000_00FF; // write-only, reads ones
          PBSEL_OFS_PAT:  rdat_nxt = {24'h00_0000, pat_r};
          PBSEL_OFS_PIN:  rdat_nxt = {24'h00_0000, lvl_r};
          default:        rdat_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // register bank; software standby simply holds (no clear)
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hw_standby_i)
    begin
      data_r <= PBSEL_DATA_RST;
      dir_r  <= PBSEL_DIR_RST;
      pat_r  <= PBSEL_PAT_RST;
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
      lvl_r  <= 8'h00;
    end
    else
    begin
      data_r <= data_nxt;
      dir_r  <= dir_nxt;
      pat_r  <= pat_nxt;
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
      lvl_r  <= lvl_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_comb
  begin
    area4  = covers(ctrl_i.dram_area_select, 1'b1);
    area5  = covers(ctrl_i.dram_area_select, 1'b0);
    cas_on = periph_i.cas_enable;
    for (int i = 0; i < 8; i++)
    begin
      pin_oe_o[i] = dir_r[i];
      pin_o[i]    = pat_r[i] ? periph_i.pattern_out[i] : data_r[i];
    end
    if (ctrl_i.rx_enable || ctrl_i.smart_card_flag)
    begin
      pin_oe_o[PBSEL_PIN_RX] = 1'b0;
      pin_o[PBSEL_PIN_RX]    = 1'b0;
    end
    if (ctrl_i.tx_enable || ctrl_i.smart_card_flag)
    begin
      pin_o[PBSEL_PIN_TX]    = periph_i.serial2_transmit;
      pin_oe_o[PBSEL_PIN_TX] = ctrl_i.smart_card_flag ?
                               periph_i.serial2_tx_drive : 1'b1;
    end
    if (ctrl_i.clock_enable_bit1)
    begin
      pin_oe_o[PBSEL_PIN_SCK] = 1'b0;
      pin_o[PBSEL_PIN_SCK]    = 1'b0;
    end
    else if (ctrl_i.sync_mode || ctrl_i.clock_enable_bit0)
    begin
      pin_oe_o[PBSEL_PIN_SCK] = 1'b1;
      pin_o[PBSEL_PIN_SCK]    = periph_i.serial2_clock_out;
    end
    if (cas_on)
    begin
      pin_oe_o[PBSEL_PIN_UPPER_COLUMN_STROBE] = 1'b1;
      pin_o[PBSEL_PIN_UPPER_COLUMN_STROBE]    = periph_i.upper_column_strobe;
      pin_oe_o[PBSEL_PIN_SCK]  = 1'b1;
      pin_o[PBSEL_PIN_SCK]     = periph_i.lower_column_strobe;
    end
    if (area4 || ctrl_i.select4_enable)
    begin
      pin_oe_o[PBSEL_PIN_3] = 1'b1;
      pin_o[PBSEL_PIN_3]    = periph_i.select_n[4];
    end
    if (!area4 && ctrl_i.timer_output_select_nz[3])
    begin
      pin_oe_o[PBSEL_PIN_3] = 1'b1;
      pin_o[PBSEL_PIN_3]    = periph_i.timer_out[3];
    end
    if (area5 || ctrl_i.select5_enable)
    begin
      pin_oe_o[PBSEL_PIN_2] = 1'b1;
      pin_o[PBSEL_PIN_2]    = periph_i.select_n[5];
    end
    if (!area5 && ctrl_i.timer_output_select_nz[2])
    begin
      pin_oe_o[PBSEL_PIN_2] = 1'b1;
      pin_o[PBSEL_PIN_2]    = periph_i.timer_out[2];
    end
    if (ctrl_i.timer_output_select_nz[1] || ctrl_i.select6_enable)
    begin
      pin_oe_o[PBSEL_PIN_1] = 1'b1;
      pin_o[PBSEL_PIN_1]    = ctrl_i.timer_output_select_nz[1] ?
                              periph_i.timer_out[1] : periph_i.select_n[6];
    end
    if (ctrl_i.timer_output_select_nz[0] || ctrl_i.select7_enable)
    begin
      pin_oe_o[PBSEL_PIN_0] = 1'b1;
      pin_o[PBSEL_PIN_0]    = ctrl_i.timer_output_select_nz[0] ?
                              periph_i.timer_out[0] : periph_i.select_n[7];
    end
  end

  // input feeds to peripherals from synchronised levels
  always_comb
  begin
    feed_o.serial2_receive  = lvl_r[PBSEL_PIN_RX];
    feed_o.serial2_clock_in = ctrl_i.clock_enable_bit1 & ~cas_on &
                              lvl_r[PBSEL_PIN_SCK];
    feed_o.timer3_pin = ctrl_i.counter_clear_sel_hi[1] &
                        ctrl_i.counter_clear_sel_lo[1] & lvl_r[PBSEL_PIN_3];
    feed_o.timer1_pin = ctrl_i.counter_clear_sel_hi[0] &
                        ctrl_i.counter_clear_sel_lo[0] & lvl_r[PBSEL_PIN_1];
    feed_o.dma_request_1 = ctrl_i.dma_ext_request & lvl_r[PBSEL_PIN_3];
    feed_o.dma_request_0 = ctrl_i.dma_ext_request & lvl_r[PBSEL_PIN_1];
  end

  // data cleared one edge after reset
  a_data_reset: assert property (@(posedge clk_i)
    (rst_i || hw_standby_i) |=> (data_r == 8'h00 && dir_r == 8'h00))
    else $error("port registers not cleared");

  a_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hw_standby_i && !(wb_cyc_i && wb_stb_i)) |=> $stable(data_r))
    else $error("data register changed without write");

  a_rx_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.rx_enable || ctrl_i.smart_card_flag) |-> !pin_oe_o[7])
    else $error("receive pin driven");

  a_tx_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.tx_enable && !ctrl_i.smart_card_flag) |->
      (pin_oe_o[6] && pin_o[6] == periph_i.serial2_transmit))
    else $error("transmit pin not driven");

  a_cas_out: assert property (@(posedge clk_i) disable iff (rst_i)
    cas_on |-> (pin_oe_o[4] && pin_o[4] == periph_i.upper_column_strobe &&
                pin_oe_o[5] && pin_o[5] == periph_i.lower_column_strobe))
    else $error("column strobe missing");

  // row strobe wins on pin 3
  a_pin3_ras: assert property (@(posedge clk_i) disable iff (rst_i)
    area4 |-> (pin_oe_o[3] && pin_o[3] == periph_i.select_n[4]))
    else $error("pin 3 row strobe lost");

  a_free_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (dir_r[0] && !pat_r[0] && !ctrl_i.timer_output_select_nz[0] &&
     !ctrl_i.select7_enable) |-> (pin_o[0] == data_r[0]))
    else $error("pin 0 does not follow data");

  a_read_mix: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && wb_adr_i == 4'h0) |=>
      (wb_ack_o && wb_dat_o[7:0] ==
       (($past(data_r) & $past(dir_r)) | ($past(lvl_r) & ~$past(dir_r)))))
    else $error("port read wrong");

  a_sck_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.clock_enable_bit1 && !cas_on) |-> !pin_oe_o[5])
    else $error("serial clock pin driven");

  // row strobe wins on pin 2
  a_pin2_ras: assert property (@(posedge clk_i) disable iff (rst_i)
    area5 |-> (pin_oe_o[2] && pin_o[2] == periph_i.select_n[5]))
    else $error("pin 2 row strobe lost");

  a_pin1_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.timer_output_select_nz[1] |->
      (pin_oe_o[1] && pin_o[1] == periph_i.timer_out[1]))
    else $error("pin 1 timer output lost");

  a_pin0_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.timer_output_select_nz[0] |->
      (pin_oe_o[0] && pin_o[0] == periph_i.timer_out[0]))
    else $error("pin 0 timer output lost");

  a_timer_feed: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.counter_clear_sel_hi[1] && ctrl_i.counter_clear_sel_lo[1]) |->
      (feed_o.timer3_pin == lvl_r[3]))
    else $error("timer input not fed");

  a_dma_feed: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.dma_ext_request |->
      (feed_o.dma_request_1 == lvl_r[3] && feed_o.dma_request_0 == lvl_r[1]))
    else $error("dma request not fed");

  a_dir_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hw_standby_i && !(wb_cyc_i && wb_stb_i)) |=> $stable(dir_r))
    else $error("direction changed without write");

endmodule
`default_nettype wire

// *** pbsel_unit_model.sv ***
// model of the neighbour units that feed the port pin selector
`timescale 1ns/1ns
`default_nettype none
module pbsel_unit_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cas_en_i,
  output pbsel_pkg::pbsel_periph_t periph_o
);
  import pbsel_pkg::*;
  logic [7:0] cnt_r;
  // free-running source so a stale pin value never passes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_r + 8'h01;
  end
  // timer outputs always differ from the matching select lines
  always_comb
  begin
    periph_o = '0;
    periph_o.pattern_out = cnt_r;
    periph_o.serial2_transmit = cnt_r[0];
    periph_o.serial2_tx_drive = cnt_r[1];
    periph_o.serial2_clock_out = cnt_r[2];
    periph_o.upper_column_strobe = cnt_r[3];
    periph_o.lower_column_strobe = ~cnt_r[3];
    periph_o.cas_enable = cas_en_i;
    periph_o.timer_out = ~{cnt_r[0], cnt_r[1], cnt_r[2], cnt_r[3]};
    periph_o.select_n = cnt_r[3:0];
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the port pin function selector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pbsel_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          hw_sb = 1'b0;
  logic          cyc = 1'b0;
  logic          stb = 1'b0;
  logic          we = 1'b0;
  logic [3:0]    adr = 4'h0;
  logic [31:0]   wdat = 32'h0;
  logic          cas_en = 1'b0;
  logic [7:0]    ext = 8'hBE;
  pbsel_ctrl_t   ctrl = '0;
  pbsel_periph_t per;
  pbsel_feed_t   feed;
  logic [31:0]   rdat;
  logic          ack;
  logic [7:0]    po;
  logic [7:0]    oe;
  logic [7:0]    pads;
  logic [7:0]    q;
  int            num_errors = 0;
  int            n_compared = 0;

  // clock and pad resolution
  always #20 clk_i = ~clk_i;
  assign pads = (oe & po) | (~oe & ext);

  pbsel_unit_model u_pbsel_unit_model (.clk_i(clk_i), .rst_i(rst_i),
    .cas_en_i(cas_en), .periph_o(per));
  pbsel_top u_pbsel_top (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_sb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ctrl_i(ctrl), .periph_i(per), .feed_o(feed), .pin_i(pads),
    .pin_o(po), .pin_oe_o(oe));

  // verdict and end of run
  task complete_run;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare one byte of results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic wishbone cycle, read data left in q
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t no bus answer", $time);
      complete_run;
    end
  endtask

  // apply neighbour controls, then sample once settled
  task setc(input pbsel_ctrl_t c, input logic ce);
    @(posedge clk_i);
    ctrl <= c;
    cas_en <= ce;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // main sequence
  initial
  begin
    pbsel_ctrl_t c;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, ext);
    chk(oe, PBSEL_DIR_RST);
    wb(1'b0, PBSEL_OFS_DIR, 8'h00);
    chk(q, 8'hFF);
    wb(1'b1, PBSEL_OFS_DIR, 8'hFF);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, PBSEL_DATA_RST);
    wb(1'b1, PBSEL_OFS_DATA, 8'hA5);
    wb(1'b1, 4'h2, 8'hFF);
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, 8'hA5);
    chk(po, 8'hA5);
    wb(1'b1, PBSEL_OFS_PAT, 8'hFF);
    setc('0, 1'b0);
    chk(po, per.pattern_out);
    wb(1'b1, PBSEL_OFS_PAT, 8'h00);
    wb(1'b1, PBSEL_OFS_DIR, 8'h0F);
    setc('0, 1'b0);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, 8'hB5);
    chk(oe, 8'h0F);
    wb(1'b1, PBSEL_OFS_DIR, 8'hFF);
    c = '0;
    c.rx_enable = 1'b1;
    setc(c, 1'b0);
    chk({6'h0, oe[7], feed.serial2_receive}, {7'h0, pads[7]});
    c = '0;
    c.smart_card_flag = 1'b1;
    setc(c, 1'b0);
    chk({5'h0, oe[7:6], po[6]}, {6'h0, per.serial2_tx_drive,
      per.serial2_transmit});
    c = '0;
    c.tx_enable = 1'b1;
    setc(c, 1'b0);
    chk({6'h0, oe[6], po[6]}, {7'h1, per.serial2_transmit});
    c = '0;
    c.clock_enable_bit1 = 1'b1;
    c.sync_mode = 1'b1;
    setc(c, 1'b0);
    chk({6'h0, oe[5], feed.serial2_clock_in}, {7'h0, pads[5]});
    c.clock_enable_bit1 = 1'b0;
    setc(c, 1'b0);
    chk({6'h0, oe[5], po[5]}, {7'h1, per.serial2_clock_out});
    setc(c, 1'b1);
    chk({4'h0, oe[5:4], po[5:4]}, {6'h3, per.lower_column_strobe,
      per.upper_column_strobe});
    c = '0;
    c.dram_area_select = 3'h4;
    c.timer_output_select_nz = 4'hF;
    setc(c, 1'b0);
    chk({4'h0, po[3:0]}, {4'h0, per.select_n[4], per.select_n[5],
      per.timer_out[1:0]});
    c.dram_area_select = 3'h0;
    c.select4_enable = 1'b1;
    c.select5_enable = 1'b1;
    c.select6_enable = 1'b1;
    c.select7_enable = 1'b1;
    setc(c, 1'b0);
    chk({4'h0, po[3:0]}, {4'h0, per.timer_out});
    c = '0;
    c.select4_enable = 1'b1;
    c.select5_enable = 1'b1;
    c.select6_enable = 1'b1;
    c.select7_enable = 1'b1;
    setc(c, 1'b0);
    chk({4'h0, po[3:0]}, {4'h0, per.select_n[4], per.select_n[5],
      per.select_n[6], per.select_n[7]});
    wb(1'b1, PBSEL_OFS_DIR, 8'h00);
    c = '0;
    c.counter_clear_sel_hi = 2'h3;
    c.counter_clear_sel_lo = 2'h3;
    c.dma_ext_request = 1'b1;
    setc(c, 1'b0);
    chk({4'h0, feed.timer3_pin, feed.timer1_pin, feed.dma_request_1,
      feed.dma_request_0},
      {4'h0, pads[3], pads[1], pads[3], pads[1]});
    setc('0, 1'b0);
    chk({4'h0, feed.timer3_pin, feed.timer1_pin, feed.dma_request_1,
      feed.dma_request_0}, 8'h00);
    wb(1'b1, PBSEL_OFS_DIR, 8'hFF);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, 8'hA5);
    @(posedge clk_i);
    hw_sb <= 1'b1;
    @(posedge clk_i);
    hw_sb <= 1'b0;
    @(negedge clk_i);
    chk(oe, 8'h00);
    wb(1'b1, PBSEL_OFS_DIR, 8'hFF);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, 8'h00);
    // reset again in mid-run with data held in the register
    wb(1'b1, PBSEL_OFS_DATA, 8'h3C);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(oe, PBSEL_DIR_RST);
    wb(1'b1, PBSEL_OFS_DIR, 8'hFF);
    wb(1'b0, PBSEL_OFS_DATA, 8'h00);
    chk(q, PBSEL_DATA_RST);
    complete_run;
  end
endmodule
`default_nettype wire
